// File: verilog/flash_status_poller.sv
// Purpose: host side poller that waits out flash program and erase operations
// Assumes: the caller has just written the program or erase command itself
// Notes: result reported once per request; failure path issues the reset command
`timescale 1ns/1ns
module flash_status_poller
  import flash_poll_pkg::*;
(
  input wire logic ref_clk, // 20 MHz clock
  input wire logic rst, // synchronous reset, high
  input wire logic clk_en, // freezes all state when low
  input wire logic req_valid, // start a status check
  input wire poll_mode_t req_mode, // which status method
  input wire logic [ADDR_W-1:0] req_addr, // poll valid address
  input wire logic [7:0] req_expect, // datum written, for data polling
  output logic req_ready_q, // idle and accepting
  output logic res_valid_q, // one-cycle result pulse
  output logic [1:0] res_code_q, // ok, fail or none
  output logic [DATA_W-1:0] res_data_q, // final word read
  output logic busy_seen_q, // ready/busy pin sampled low
  output logic ce_n_q, // flash chip enable
  output logic oe_n_q, // flash output enable
  output logic we_n_q, // flash write strobe
  output logic [ADDR_W-1:0] a_q, // flash address
  output logic [DATA_W-1:0] dq_out_q, // flash data out
  output logic dq_oe_q, // high while driving data
  input wire logic [DATA_W-1:0] dq_in, // flash data in, asynchronous
  input wire logic ready_busy_n // open-drain status pin with pull-up
);
  typedef enum {ST_IDLE, ST_FIRST, ST_READ, ST_FINAL, ST_RESET, ST_GAP} state_t;
  state_t state_q, state_d;
  logic [DATA_W-1:0] dq_meta_q, dq_sync_q;
  logic rb_meta_q, rb_sync_q;
  logic [ADDR_W-1:0] addr_q;
  logic [7:0] expect_q;
  logic [7:0] gap_q;
  poll_mode_t mode_q;
  logic prev_tog_q;
  logic timeout_seen_q;
  logic [1:0] code_q;
  flash_cycle_if cyc ();
  // two-stage synchronisers; only the second stage is read
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dq_meta_q <= '0;
      dq_sync_q <= '0;
      rb_meta_q <= 1'b1;
      rb_sync_q <= 1'b1;
    end else if (clk_en) begin
      dq_meta_q <= dq_in;
      dq_sync_q <= dq_meta_q;
      rb_meta_q <= ready_busy_n;
      rb_sync_q <= rb_meta_q;
    end
  end
  flash_cycle u_cycle (
    .ref_clk(ref_clk),
    .rst(rst),
    .clk_en(clk_en),
    .cyc(cyc.engine),
    .dq_sync(dq_sync_q),
    .ce_n_q(ce_n_q),
    .oe_n_q(oe_n_q),
    .we_n_q(we_n_q),
    .a_q(a_q),
    .dq_out_q(dq_out_q),
    .dq_oe_q(dq_oe_q)
  );
  // decode of the word just read
  wire [DATA_W-1:0] rd = cyc.rdata;
  wire tog_now = rd[TOGGLE_ONE_POS];
  wire tog_same = tog_now == prev_tog_q;
  wire poll_match = rd[DATA_POLL_POS] == expect_q[DATA_POLL_POS];
  wire to_flag = rd[TIMEOUT_POS];
  wire timer_done = rd[ERASE_TIMER_POS];
  wire op_done = (mode_q == MODE_TOGGLE) ? tog_same : poll_match;
  // a gap between polls; reads always use the caller's valid address in the busy bank
  wire gap_done = gap_q == 8'h00;
  assign cyc.start = (state_q == ST_FIRST || state_q == ST_READ || state_q == ST_FINAL ||
                      state_q == ST_RESET) && !cyc.done && gap_done;
  assign cyc.write = state_q == ST_RESET;
  assign cyc.addr = addr_q;
  assign cyc.wdata = RESET_CMD;
  // named conditions for the bookkeeping processes
  wire req_take = state_q == ST_IDLE && req_valid && req_ready_q;
  wire first_done = state_q == ST_FIRST && cyc.done;
  wire read_done = state_q == ST_READ && cyc.done;
  wire timer_read = first_done && mode_q == MODE_ERASE_TIMER;
  wire to_sample = (read_done && !op_done) || (first_done && mode_q != MODE_ERASE_TIMER);
  wire gap_load = state_d == ST_GAP && state_q != ST_GAP;
  wire result_now = state_q != ST_IDLE && state_d == ST_IDLE;
  // timer check is a single read: ok once the timer has expired, none while it still runs
  wire [1:0] timer_code = timer_done ? RESULT_OK : RESULT_NONE;
  wire [1:0] result_code = timer_read ? timer_code : code_q;
  // sequencing of the polling algorithms
  // a check in progress cannot be abandoned; the caller waits for its result
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: if (req_take) state_d = ST_FIRST;
      ST_FIRST: if (cyc.done) state_d = (mode_q == MODE_ERASE_TIMER) ? ST_IDLE : ST_GAP;
      ST_GAP: if (gap_done) state_d = ST_READ;
      ST_READ: begin
        if (cyc.done) begin
          if (op_done) state_d = ST_FINAL;
          else if (timeout_seen_q) state_d = ST_RESET;
          else state_d = ST_GAP;
        end
      end
      ST_FINAL: if (cyc.done) state_d = ST_IDLE;
      ST_RESET: if (cyc.done) state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end
  // state register; the machine only moves while the clock enable is high
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
    end else if (clk_en) begin
      state_q <= state_d;
    end
  end
  // request capture; fields are held for the whole check so the poll address never drifts
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      addr_q <= '0;
      expect_q <= 8'h00;
      mode_q <= MODE_TOGGLE;
    end else if (clk_en && req_take) begin
      addr_q <= req_addr;
      expect_q <= req_expect;
      mode_q <= req_mode;
    end
  end
  // toggle history; every finished read refreshes it, so a new check starts from its own first read
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prev_tog_q <= 1'b0;
    end else if (clk_en && cyc.done) begin
      prev_tog_q <= tog_now;
    end
  end
  // timeout is sampled on the first read and on each read that still shows busy; then one recheck
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      timeout_seen_q <= 1'b0;
    end else if (clk_en) begin
      if (req_take) timeout_seen_q <= 1'b0;
      else if (to_sample) timeout_seen_q <= to_flag;
    end
  end
  // poll gap counter; spacing the reads keeps bus traffic low while the flash works
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      gap_q <= 8'h00;
    end else if (clk_en) begin
      if (gap_load) gap_q <= POLL_GAP_VAL;
      else if (!gap_done) gap_q <= gap_q - 8'h01;
    end
  end
  // verdict of the latest status read, handed out when the check ends
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      code_q <= RESULT_OK;
    end else if (clk_en && read_done) begin
      code_q <= op_done ? RESULT_OK : RESULT_FAIL;
    end
  end
  // handshake outputs registered from the next state
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      req_ready_q <= 1'b0;
      res_valid_q <= 1'b0;
    end else if (clk_en) begin
      req_ready_q <= state_d == ST_IDLE;
      res_valid_q <= result_now;
    end
  end
  // result fields stand until the next result
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      res_code_q <= RESULT_OK;
      res_data_q <= '0;
    end else if (clk_en && result_now) begin
      res_code_q <= result_code;
      res_data_q <= rd;
    end
  end
  // ready/busy pin after its synchroniser; one more flop keeps the output registered
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      busy_seen_q <= 1'b0;
    end else if (clk_en) begin
      busy_seen_q <= !rb_sync_q;
    end
  end
endmodule // flash_status_poller

// File: verilog/flash_poll_pkg.sv
// Purpose: constants shared by the flash status poller and its bus cycle engine
// Assumes: 16-bit parallel NOR flash, asynchronous strobes, 20 MHz controller clock
// Notes: bit positions are those of the status word on the data bus
package flash_poll_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 22;
  localparam int unsigned DATA_POLL_POS = 7;
  localparam int unsigned TOGGLE_ONE_POS = 6;
  localparam int unsigned TIMEOUT_POS = 5;
  localparam int unsigned ERASE_TIMER_POS = 3;
  localparam int unsigned TOGGLE_TWO_POS = 2;
  // strobe phase lengths in cycles of the controller clock
  localparam int unsigned SETUP_CYC = 2;
  localparam int unsigned STROBE_CYC = 4;
  localparam int unsigned HOLD_CYC = 2;
  localparam logic [3:0] PHASE_LAST = 4'h8;
  // spacing between polls while the host waits
  localparam int unsigned POLL_GAP_NS = 1000;
  localparam int unsigned POLL_GAP_CYC = (POLL_GAP_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam logic [7:0] POLL_GAP_VAL = 8'(POLL_GAP_CYC);
  localparam logic [15:0] RESET_CMD = 16'h00f0;
  localparam logic [1:0] RESULT_OK = 2'h0;
  localparam logic [1:0] RESULT_FAIL = 2'h1;
  localparam logic [1:0] RESULT_NONE = 2'h2;
  typedef enum logic [1:0] {MODE_TOGGLE, MODE_DATA_POLL, MODE_ERASE_TIMER} poll_mode_t;
endpackage

// File: verilog/flash_cycle_if.sv
// Purpose: request and answer bundle between poller and bus cycle engine
// Assumes: one cycle in flight at a time
// Notes: done pulses one clock when the strobe has ended
`timescale 1ns/1ns
interface flash_cycle_if;
  import flash_poll_pkg::*;
  logic start;
  logic write;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic done;
  logic [DATA_W-1:0] rdata;
  modport master (output start, output write, output addr, output wdata, input done, input rdata);
  modport engine (input start, input write, input addr, input wdata, output done, output rdata);
endinterface

// File: verilog/flash_cycle.sv
// Purpose: one asynchronous read or write cycle on the flash pins
// Assumes: data input already passed through a two-stage synchroniser
// Notes: read data is captured in the last strobe cycle, before the strobe rises
`timescale 1ns/1ns
module flash_cycle
  import flash_poll_pkg::*;
(
  input wire logic ref_clk, // controller clock
  input wire logic rst, // synchronous reset
  input wire logic clk_en, // freezes state when low
  flash_cycle_if.engine cyc, // cycle request
  input wire logic [DATA_W-1:0] dq_sync, // synchronised data bus
  output logic ce_n_q, // chip enable
  output logic oe_n_q, // output enable
  output logic we_n_q, // write strobe
  output logic [ADDR_W-1:0] a_q, // address pins
  output logic [DATA_W-1:0] dq_out_q, // data driven out
  output logic dq_oe_q // high while driving data
);
  logic [3:0] phase_q;
  logic busy_q;
  logic wr_q;
  logic [DATA_W-1:0] rdata_q;
  logic done_q;
  wire in_strobe = busy_q && phase_q >= 4'(SETUP_CYC) && phase_q < 4'(SETUP_CYC + STROBE_CYC);
  wire capture = busy_q && !wr_q && phase_q == 4'(SETUP_CYC + STROBE_CYC - 1);
  wire finish = busy_q && phase_q == PHASE_LAST - 4'h1;
  assign cyc.done = done_q;
  assign cyc.rdata = rdata_q;
  // phase counter walks setup, strobe, hold
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      phase_q <= 4'h0;
      busy_q <= 1'b0;
      wr_q <= 1'b0;
      done_q <= 1'b0;
      rdata_q <= '0;
      a_q <= '0;
      dq_out_q <= '0;
    end else if (clk_en) begin
      done_q <= finish;
      if (!busy_q && cyc.start) begin
        busy_q <= 1'b1;
        wr_q <= cyc.write;
        a_q <= cyc.addr;
        dq_out_q <= cyc.wdata;
        phase_q <= 4'h0;
      end else if (busy_q) begin
        phase_q <= phase_q + 4'h1;
        if (finish) busy_q <= 1'b0;
      end
      if (capture) rdata_q <= dq_sync;
    end
  end
  // pin strobes; each status read is a complete ce and oe frame
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ce_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      we_n_q <= 1'b1;
      dq_oe_q <= 1'b0;
    end else if (clk_en) begin
      ce_n_q <= !in_strobe;
      oe_n_q <= !(in_strobe && !wr_q);
      we_n_q <= !(in_strobe && wr_q);
      dq_oe_q <= busy_q && wr_q && !finish;
    end
  end
endmodule // flash_cycle

// File: sim/flash_dev_model.sv
// Purpose: flash device model answering status reads on the poller's pins
// Assumes: one embedded operation at a time, one bank
// Notes: released data lines show the inverse of the last word
`timescale 1ns/1ns
module flash_dev_model
  import flash_poll_pkg::*;
(
  input wire logic ce_n, // chip enable
  input wire logic oe_n, // output enable
  input wire logic we_n, // write strobe
  input wire logic [DATA_W-1:0] dq_w, // data from host
  input wire logic dq_oe, // host drives data
  output logic [DATA_W-1:0] dq_r, // data to host
  output wire logic rb_n // open-drain busy
);
  int left, n, tmo_at;
  logic busy = 1'b0;
  logic tgl = 1'b0;
  logic erase, tmr, tmo, rst_seen;
  logic [DATA_W-1:0] mem;
  wire rd = !ce_n && !oe_n;
  wire wr = !ce_n && !we_n;
  initial dq_r = 16'h0000;
  // pulled low only while working
  assign rb_n = busy ? 1'b0 : 1'bz;
  // a new operation reports busy as soon as the bench calls start; its toggle bit flips on each status read except the one that finishes it
  task automatic start(input int r, input int t, input logic e, input logic m, input logic [15:0] d);
    left = r;
    tmo_at = t;
    erase = e;
    tmr = m;
    mem = d;
    n = 0;
    tmo = 1'b0;
    rst_seen = 1'b0;
    busy = 1'b1;
  endtask
  // status while busy, array data once done
  always @(posedge rd) begin
    if (busy) begin
      n++;
      tmo = tmo | (n == tmo_at); // pulse limit passed
      // finished after left status reads; with left 0 only the reset command ends it
      if (n == left) begin
        busy = 1'b0;
        dq_r = ~mem; // other lines still settling
        dq_r[7:6] = {mem[7], tgl}; // toggling stops
      end else begin
        tgl = ~tgl;
        dq_r = {8'h00, ~mem[7] & !erase, tgl, tmo, 1'b0, tmr & erase, tgl & erase, 2'b00};
      end
    end else dq_r = mem; // one bank: array data once idle
  end
  // a released bus must not keep the old word
  always @(negedge rd) dq_r = ~dq_r;
  // reset command ends a failed operation; no other command is honoured
  always @(posedge wr) if (dq_oe && dq_w == RESET_CMD) begin
    busy = 1'b0;
    rst_seen = 1'b1;
  end
endmodule // flash_dev_model

// File: sim/poller_monitor.sv
// Purpose: port checker for the status poller
// Assumes: clk_en held high, so strobe phases run at full rate
// Notes: helper counts restart when a request is taken
`timescale 1ns/1ns
module poller_monitor
  import flash_poll_pkg::*;
(
  input wire logic ref_clk, // clock
  input wire logic rst, // reset
  input wire logic req_valid, // request
  input wire poll_mode_t req_mode, // mode
  input wire logic [ADDR_W-1:0] req_addr, // poll address
  input wire logic req_ready_q, // idle
  input wire logic res_valid_q, // result pulse
  input wire logic [1:0] res_code_q, // result code
  input wire logic ce_n_q, // chip enable
  input wire logic oe_n_q, // output enable
  input wire logic we_n_q, // write strobe
  input wire logic [ADDR_W-1:0] a_q, // address pins
  input wire logic [DATA_W-1:0] dq_out_q, // data out
  input wire logic dq_oe_q // drive enable
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [7:0] rd_n_q;
  logic wr_seen_q;
  logic [ADDR_W-1:0] addr_q;
  poll_mode_t mode_q;
  wire take = req_valid && req_ready_q;
  // reads and writes since the request was taken
  always_ff @(posedge ref_clk) begin
    if (rst || take) begin
      rd_n_q <= 8'h00;
      wr_seen_q <= 1'b0;
    end else begin
      rd_n_q <= rd_n_q + 8'($fell(oe_n_q));
      wr_seen_q <= wr_seen_q | $fell(we_n_q);
    end
    if (take) begin
      addr_q <= req_addr;
      mode_q <= req_mode;
    end
  end
  a_strobe_width: assert property ($fell(oe_n_q) |=> !oe_n_q [*3] ##1 oe_n_q) else $error("read strobe width");
  a_read_address: assert property (!oe_n_q |-> a_q == addr_q) else $error("poll address lost");
  a_no_contention: assert property (!oe_n_q |-> !dq_oe_q) else $error("drive during read");
  a_result_pulse: assert property (res_valid_q |=> !res_valid_q) else $error("result longer than a cycle");
  a_idle_quiet: assert property (req_ready_q |-> ce_n_q && oe_n_q && we_n_q) else $error("strobe while idle");
  a_reset_cmd: assert property ($fell(we_n_q) |-> dq_oe_q && dq_out_q == RESET_CMD) else $error("bad write");
  a_toggle_reads: assert property (res_valid_q && res_code_q == RESULT_OK && mode_q == MODE_TOGGLE
    |-> rd_n_q >= 8'h03) else $error("toggle ok too soon");
  a_poll_reads: assert property (res_valid_q && res_code_q == RESULT_OK && mode_q == MODE_DATA_POLL
    |-> rd_n_q >= 8'h02) else $error("poll ok too soon");
  a_fail_reset: assert property (res_valid_q && res_code_q == RESULT_FAIL |-> wr_seen_q) else $error("no reset");
endmodule // poller_monitor
bind flash_status_poller poller_monitor u_poller_monitor (.ref_clk, .rst, .req_valid, .req_mode, .req_addr,
  .req_ready_q, .res_valid_q, .res_code_q, .ce_n_q, .oe_n_q, .we_n_q, .a_q, .dq_out_q, .dq_oe_q);

// File: sim/tb_flash_status_poller.sv
// Purpose: self-checking bench for the status poller
// Assumes: clk_en held high; the device model sits on the flash pins
// Notes: expectations come from each scenario's own settings
`timescale 1ns/1ns
module tb_flash_status_poller;
  import flash_poll_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic req_valid = 1'b0;
  poll_mode_t req_mode = MODE_TOGGLE;
  logic [ADDR_W-1:0] req_addr = '0;
  logic [7:0] req_expect = 8'h00;
  logic req_ready_q, res_valid_q, busy_seen_q, ce_n_q, oe_n_q, we_n_q, dq_oe_q;
  logic [1:0] res_code_q;
  logic [DATA_W-1:0] res_data_q, dq_out_q, dq_in;
  logic [ADDR_W-1:0] a_q;
  tri1 rb_w;
  int failures = 0;
  int check_count = 0;
  int cyc = 0;
  flash_status_poller u_flash_status_poller (.ref_clk, .rst, .clk_en, .req_valid, .req_mode, .req_addr, .req_expect,
    .req_ready_q, .res_valid_q, .res_code_q, .res_data_q, .busy_seen_q, .ce_n_q, .oe_n_q, .we_n_q, .a_q,
    .dq_out_q, .dq_oe_q, .dq_in, .ready_busy_n(rb_w));
  flash_dev_model u_flash_dev_model (.ce_n(ce_n_q), .oe_n(oe_n_q), .we_n(we_n_q), .dq_w(dq_out_q),
    .dq_oe(dq_oe_q), .dq_r(dq_in), .rb_n(rb_w));
  initial forever #25 ref_clk = ~ref_clk;
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // cut a hang short
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      complete_run();
    end
  end
  // start a device operation, run one request, hold the result up against the bench model
  task automatic poll(input poll_mode_t m, input logic [15:0] d, input int r, input int t, input logic e,
    input logic tm);
    logic [1:0] code;
    int w;
    code = (m == MODE_ERASE_TIMER) ? (tm ? RESULT_OK : RESULT_NONE) : (r == 0 ? RESULT_FAIL : RESULT_OK);
    w = 0;
    u_flash_dev_model.start(r, t, e, tm, d);
    while (req_ready_q !== 1'b1) begin
      @(posedge ref_clk);
      #1;
    end
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req_mode <= m;
    req_addr <= ADDR_W'($urandom);
    req_expect <= d[7:0];
    @(posedge ref_clk);
    req_valid <= 1'b0;
    while (res_valid_q !== 1'b1 && w < 3000) begin
      @(posedge ref_clk);
      #1;
      w++;
    end
    if (w == 3000) begin
      failures++;
      complete_run();
    end
    check({14'h0000, res_code_q}, {14'h0000, code});
    check({15'h0000, busy_seen_q}, {15'h0000, m == MODE_ERASE_TIMER});
    check({15'h0000, u_flash_dev_model.rst_seen}, {15'h0000, r == 0 && m != MODE_ERASE_TIMER});
    if (code == RESULT_OK && m != MODE_ERASE_TIMER) check(res_data_q, d);
  endtask
  initial begin
    logic [15:0] d;
    void'($urandom(32'h34c2dcee));
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    poll(MODE_TOGGLE, 16'hffff, 3, 0, 1'b1, 1'b0);
    poll(MODE_DATA_POLL, 16'hffff, 4, 0, 1'b1, 1'b0);
    poll(MODE_TOGGLE, 16'h1234, 0, 3, 1'b0, 1'b0);
    poll(MODE_DATA_POLL, 16'h0f0f, 5, 4, 1'b0, 1'b0);
    poll(MODE_ERASE_TIMER, 16'hffff, 0, 0, 1'b1, 1'b0);
    poll(MODE_ERASE_TIMER, 16'hffff, 0, 0, 1'b1, 1'b1);
    for (int k = 0; k < 12; k++) begin
      d = 16'($urandom);
      poll(poll_mode_t'(k % 2), d, 2 + $urandom_range(4), 0, 1'b0, 1'b0);
    end
    complete_run();
  end
endmodule // tb_flash_status_poller
